// ==== serial_board_io_status_regs.sv ====
`timescale 1ns/100ps
module serial_board_io_status_regs (
    // Clock and reset
    input  wire logic                                  i_clk,
    input  wire logic                                  i_resetn,
    // Host register port
    input  wire logic [7:0]                            i_reg_addr,
    input  wire logic                                  i_reg_wr,
    input  wire logic                                  i_reg_rd,
    input  wire logic [31:0]                           i_reg_wdata,
    output logic      [31:0]                           o_reg_rdata,
    // Base control and interrupt lines
    input  wire serial_board_io_status_pkg::irq_ctrl_t  i_irq_ctrl,
    input  wire serial_board_io_status_pkg::irq_lines_t i_irq_lines,
    input  wire logic [1:0]                            i_full_duplex,
    output logic                                       o_irq,
    // UART channel status
    input  wire logic [3:0]                            i_uart_rx_ready,
    input  wire logic [3:0]                            i_uart_tx_ready,
    input  wire logic [3:0]                            i_bg_read_en,
    // Rx data read timing
    input  wire logic [3:0]                            i_rx_read_start,
    input  wire logic                                  i_rx_read_done,
    output logic                                       o_rx_read_abort,
    output logic      [15:0]                           o_abort_data,
    // User switch
    input  wire logic [7:0]                            i_user_switch_bits,
    // Bidirectional differential lines
    input  wire logic [15:0]                           i_line_in,
    input  wire logic [15:0]                           i_sys_line_out,
    input  wire logic [15:0]                           i_sys_line_oe,
    output logic      [15:0]                           o_line_out,
    output logic      [15:0]                           o_line_oe,
    output logic      [15:0]                           o_line_term,
    // RS-232 and auxiliary lines
    input  wire logic [7:0]                            i_uart_out,
    input  wire logic [1:0]                            i_controller_sync,
    input  wire logic [7:0]                            i_rs232_in,
    input  wire logic [1:0]                            i_aux_in,
    output logic      [7:0]                            o_rs232_out,
    output logic      [1:0]                            o_aux_out,
    output logic      [1:0]                            o_aux_oe
);

    // Register storage
    logic [15:0] term_q;
    logic [15:0] dir_q;
    logic [15:0] diff_src_q;
    logic [15:0] diff_out_q;
    logic [9:0]  rs_src_q;
    logic [9:0]  rs_out_q;
    logic [15:0] preload_q;
    logic [15:0] tmo_data_q;
    logic        timer_latch_q;
    logic        scc_latch_q;
    logic [3:0]  uart_latch_q;
    logic [15:0] count_q;
    logic        irq_q;

    typedef enum logic [0:0] {TMO_IDLE, TMO_RUN} tmo_state_t;
    tmo_state_t  tmo_q;

    logic        irq_cond;
    logic        tmo_fire;
    logic        bg_start;
    logic [5:0]  clr_bits;
    logic [15:0] eff_oe;
    logic [31:0] status_word;
    logic [31:0] rdata_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = i_reg_wr && hit(i_reg_addr, off);
    endfunction

    assign clr_bits = wr_hit(serial_board_io_status_pkg::OFF_IRQ_STATUS) ? i_reg_wdata[15:10] : 6'h00;

    assign irq_cond = i_irq_ctrl.force_irq
                    | (timer_latch_q & i_irq_ctrl.timer_en)
                    | (i_irq_lines.sync_serial_controller & i_irq_ctrl.scc_en)
                    | (|(i_irq_lines.uart & i_irq_ctrl.uart_en));

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_cond & i_irq_ctrl.master_en;
        end
    end

    assign o_irq = irq_q;

    assign bg_start = |(i_rx_read_start & i_bg_read_en);

    assign tmo_fire = (tmo_q == TMO_RUN) && (count_q == 16'h0000) && !i_rx_read_done;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tmo_q   <= TMO_IDLE;
            count_q <= 16'h0000;
        end else begin
            case (tmo_q)
                TMO_IDLE: begin
                    if (bg_start) begin
                        tmo_q   <= TMO_RUN;
                        count_q <= preload_q;
                    end
                end
                TMO_RUN: begin
                    if (i_rx_read_done || tmo_fire) begin
                        tmo_q <= TMO_IDLE;
                    end else begin
                        count_q <= count_q - 16'h0001;
                    end
                end
                default: begin
                    tmo_q <= TMO_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_read_abort <= 1'b0;
            o_abort_data    <= 16'h0000;
        end else begin
            o_rx_read_abort <= tmo_fire;
            if (tmo_fire) begin
                o_abort_data <= tmo_data_q;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            timer_latch_q <= 1'b0;
        end else if (tmo_fire) begin
            timer_latch_q <= 1'b1;
        end else if (clr_bits[0]) begin
            timer_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scc_latch_q  <= 1'b0;
            uart_latch_q <= 4'h0;
        end else begin
            scc_latch_q  <= i_irq_lines.sync_serial_controller | (scc_latch_q & ~clr_bits[1]);
            uart_latch_q <= i_irq_lines.uart | (uart_latch_q & ~clr_bits[5:2]);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            term_q     <= serial_board_io_status_pkg::RST_LINE_TERM;
            dir_q      <= serial_board_io_status_pkg::RST_LINE_DIR;
            diff_src_q <= serial_board_io_status_pkg::RST_DIFF_SRC;
            diff_out_q <= serial_board_io_status_pkg::RST_DIFF_OUT;
        end else begin
            if (wr_hit(serial_board_io_status_pkg::OFF_LINE_TERM)) begin
                term_q <= i_reg_wdata[15:0];
            end
            if (wr_hit(serial_board_io_status_pkg::OFF_LINE_DIR)) begin
                dir_q <= i_reg_wdata[15:0];
            end
            if (wr_hit(serial_board_io_status_pkg::OFF_DIFF_SRC)) begin
                diff_src_q <= i_reg_wdata[15:0];
            end
            if (wr_hit(serial_board_io_status_pkg::OFF_DIFF_OUT)) begin
                diff_out_q <= i_reg_wdata[15:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rs_src_q   <= serial_board_io_status_pkg::RST_RS232_SRC;
            rs_out_q   <= serial_board_io_status_pkg::RST_RS232_OUT;
            preload_q  <= serial_board_io_status_pkg::RST_TMO_PRELOAD;
            tmo_data_q <= serial_board_io_status_pkg::RST_TMO_DATA;
        end else begin
            if (wr_hit(serial_board_io_status_pkg::OFF_RS232_SRC)) begin
                rs_src_q <= i_reg_wdata[9:0];
            end
            if (wr_hit(serial_board_io_status_pkg::OFF_RS232_OUT)) begin
                rs_out_q <= i_reg_wdata[9:0];
            end
            if (wr_hit(serial_board_io_status_pkg::OFF_TMO_PRELOAD)) begin
                preload_q <= i_reg_wdata[15:0];
            end
            if (wr_hit(serial_board_io_status_pkg::OFF_TMO_DATA)) begin
                tmo_data_q <= i_reg_wdata[15:0];
            end
        end
    end

    // channel A lines 7-0, B 15-8
    assign eff_oe = {(i_full_duplex[1] ? i_sys_line_oe[15:8] : dir_q[15:8]),
                     (i_full_duplex[0] ? i_sys_line_oe[7:0]  : dir_q[7:0])};

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_line_term <= 16'h0000;
            o_line_oe   <= 16'h0000;
            o_line_out  <= 16'h0000;
        end else begin
            o_line_term <= term_q;
            o_line_oe   <= eff_oe;
            o_line_out  <= (diff_src_q & diff_out_q) | (~diff_src_q & i_sys_line_out);
        end
    end

    // open drain pulls low on zero
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rs232_out <= 8'hff;
            o_aux_out   <= 2'h0;
            o_aux_oe    <= 2'h0;
        end else begin
            o_rs232_out <= (rs_src_q[7:0] & rs_out_q[7:0]) | (~rs_src_q[7:0] & i_uart_out);
            o_aux_out   <= 2'h0;
            o_aux_oe    <= ~((rs_src_q[9:8] & rs_out_q[9:8]) | (~rs_src_q[9:8] & i_controller_sync));
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[serial_board_io_status_pkg::POS_IRQ_STATUS]  = irq_cond;
        status_word[serial_board_io_status_pkg::POS_IRQ_OUT]     = irq_q;
        status_word[serial_board_io_status_pkg::POS_SCC_IN]      = i_irq_lines.sync_serial_controller;
        status_word[serial_board_io_status_pkg::POS_UART_IN +: 4] = i_irq_lines.uart;
        status_word[serial_board_io_status_pkg::POS_TIMER_LATCH] = timer_latch_q;
        status_word[serial_board_io_status_pkg::POS_SCC_LATCH]   = scc_latch_q;
        status_word[serial_board_io_status_pkg::POS_UART_LATCH +: 4] = uart_latch_q;
        status_word[serial_board_io_status_pkg::POS_RX_READY +: 4]   = i_uart_rx_ready;
        status_word[serial_board_io_status_pkg::POS_TX_READY +: 4]   = i_uart_tx_ready;
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (i_reg_addr)
            serial_board_io_status_pkg::OFF_USER_SWITCH: rdata_d = {24'h000000, i_user_switch_bits};
            serial_board_io_status_pkg::OFF_IRQ_STATUS:  rdata_d = status_word;
            serial_board_io_status_pkg::OFF_LINE_TERM:   rdata_d = {16'h0000, term_q};
            serial_board_io_status_pkg::OFF_LINE_DIR:    rdata_d = {16'h0000, dir_q};
            serial_board_io_status_pkg::OFF_DIFF_SRC:    rdata_d = {16'h0000, diff_src_q};
            serial_board_io_status_pkg::OFF_DIFF_OUT:    rdata_d = {16'h0000, diff_out_q};
            serial_board_io_status_pkg::OFF_DIFF_RDBK:   rdata_d = {16'h0000, i_line_in & ~eff_oe};
            serial_board_io_status_pkg::OFF_RS232_SRC:   rdata_d = {22'h0, rs_src_q};
            serial_board_io_status_pkg::OFF_RS232_OUT:   rdata_d = {22'h0, rs_out_q};
            serial_board_io_status_pkg::OFF_RS232_RDBK:  rdata_d = {22'h0, i_aux_in, i_rs232_in};
            serial_board_io_status_pkg::OFF_TMO_PRELOAD: rdata_d = {16'h0000, preload_q};
            serial_board_io_status_pkg::OFF_TMO_DATA:    rdata_d = {16'h0000, tmo_data_q};
            default:                                     rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
        end
    end

    // Checks
    sequence s_start;
        (tmo_q == TMO_IDLE) && bg_start;
    endsequence

    sequence s_fire;
        tmo_fire;
    endsequence

    property p_load;
        @(posedge i_clk) disable iff (!i_resetn)
        s_start |=> (tmo_q == TMO_RUN) && (count_q == $past(preload_q));
    endproperty
    a_load: assert property (p_load) else $error("counter not preloaded");

    property p_abort;
        @(posedge i_clk) disable iff (!i_resetn)
        s_fire |=> o_rx_read_abort && (o_abort_data == $past(tmo_data_q));
    endproperty
    a_abort: assert property (p_abort) else $error("abort missing or wrong data");

    property p_timer_set;
        @(posedge i_clk) disable iff (!i_resetn)
        s_fire |=> timer_latch_q;
    endproperty
    a_timer_set: assert property (p_timer_set) else $error("timer latch not set");

    property p_timer_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        timer_latch_q && !clr_bits[0] |=> timer_latch_q;
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer latch dropped");

    property p_uart_latch;
        @(posedge i_clk) disable iff (!i_resetn)
        i_irq_lines.uart[0] |=> uart_latch_q[0];
    endproperty
    a_uart_latch: assert property (p_uart_latch) else $error("uart latch missed");

    property p_irq_gate;
        @(posedge i_clk) disable iff (!i_resetn)
        !i_irq_ctrl.master_en |=> !o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq with master off");

    property p_irq_pass;
        @(posedge i_clk) disable iff (!i_resetn)
        i_irq_ctrl.master_en && i_irq_ctrl.force_irq |=> o_irq;
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("forced irq missing");

    property p_count_down;
        @(posedge i_clk) disable iff (!i_resetn)
        (tmo_q == TMO_RUN) && !tmo_fire && !i_rx_read_done |=> count_q == $past(count_q) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("counter not decrementing");

    property p_done_stop;
        @(posedge i_clk) disable iff (!i_resetn)
        (tmo_q == TMO_RUN) && i_rx_read_done |=> (tmo_q == TMO_IDLE) ##1 !o_rx_read_abort;
    endproperty
    a_done_stop: assert property (p_done_stop) else $error("counter ran after completion");

endmodule // serial_board_io_status_regs

// ==== serial_board_io_status_pkg.sv ====
package serial_board_io_status_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_USER_SWITCH   = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS    = 8'h08;
    localparam logic [7:0] OFF_LINE_TERM     = 8'h10;
    localparam logic [7:0] OFF_LINE_DIR      = 8'h14;
    localparam logic [7:0] OFF_DIFF_SRC      = 8'h18;
    localparam logic [7:0] OFF_DIFF_OUT      = 8'h1c;
    localparam logic [7:0] OFF_DIFF_RDBK     = 8'h20;
    localparam logic [7:0] OFF_RS232_SRC     = 8'h24;
    localparam logic [7:0] OFF_RS232_OUT     = 8'h28;
    localparam logic [7:0] OFF_RS232_RDBK    = 8'h2c;
    localparam logic [7:0] OFF_TMO_PRELOAD   = 8'h38;
    localparam logic [7:0] OFF_TMO_DATA      = 8'h3c;

    // Status port field positions
    localparam int POS_IRQ_STATUS   = 0;
    localparam int POS_IRQ_OUT      = 1;
    localparam int POS_SCC_IN       = 4;
    localparam int POS_UART_IN      = 5;
    localparam int POS_TIMER_LATCH  = 10;
    localparam int POS_SCC_LATCH    = 11;
    localparam int POS_UART_LATCH   = 12;
    localparam int POS_RX_READY     = 16;
    localparam int POS_TX_READY     = 20;

    // Field widths
    localparam int LINE_W   = 16;
    localparam int RS232_W  = 10;
    localparam int SWITCH_W = 8;
    localparam int TMO_W    = 16;
    localparam int NUM_UART = 4;

    // Reset values
    localparam logic [15:0] RST_LINE_TERM   = 16'h0000;
    localparam logic [15:0] RST_LINE_DIR    = 16'h0000;
    localparam logic [15:0] RST_DIFF_SRC    = 16'h0000;
    localparam logic [15:0] RST_DIFF_OUT    = 16'h0000;
    localparam logic [9:0]  RST_RS232_SRC   = 10'h000;
    localparam logic [9:0]  RST_RS232_OUT   = 10'h3ff;
    localparam logic [15:0] RST_TMO_PRELOAD = 16'hffff;
    localparam logic [15:0] RST_TMO_DATA    = 16'h0000;

    // Interrupt enables and force bit kept in the base control register outside
    typedef struct packed {
        logic       master_en;
        logic       timer_en;
        logic       force_irq;
        logic       scc_en;
        logic [3:0] uart_en;
    } irq_ctrl_t;

    // Live interrupt lines from the serial devices
    typedef struct packed {
        logic       sync_serial_controller;
        logic [3:0] uart;
    } irq_lines_t;

endpackage

// ==== serial_line_far_end.sv ====
`timescale 1ns/100ps
module serial_line_far_end (
    // Device side
    input  wire logic [15:0] i_line_oe,
    input  wire logic [15:0] i_line_out,
    // Far-end drive value
    input  wire logic [15:0] i_far_val,
    // Wire level seen by the device
    output logic      [15:0] o_line_in
);
    // Driven lines show the device, released lines the far end
    always_comb begin
        for (int k = 0; k < 16; k++) begin
            o_line_in[k] = i_line_oe[k] ? i_line_out[k] : i_far_val[k];
        end
    end
endmodule // serial_line_far_end

// ==== serial_board_io_status_regs_tb_top.sv ====
`timescale 1ns/100ps
module serial_board_io_status_regs_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [7:0]  ctrl = 8'h00;
    logic [4:0]  lines = 5'h00;
    logic [1:0]  duplex = 2'h0;
    logic        irq;
    logic [3:0]  rx_rdy = 4'h0;
    logic [3:0]  tx_rdy = 4'h0;
    logic [3:0]  bg_en = 4'h0;
    logic [3:0]  rd_start = 4'h0;
    logic        rd_done = 1'b0;
    logic        abort;
    logic [15:0] abort_data;
    logic [7:0]  sw = 8'h00;
    logic [15:0] line_in;
    logic [15:0] sys_out = 16'h0;
    logic [15:0] sys_oe = 16'h0;
    logic [15:0] line_out;
    logic [15:0] line_oe;
    logic [15:0] line_term;
    logic [15:0] far_val = 16'h0;
    logic [7:0]  uart_out = 8'h00;
    logic [1:0]  sync = 2'h0;
    logic [7:0]  rs_in = 8'h00;
    logic [1:0]  aux_in = 2'h0;
    logic [7:0]  rs_out;
    logic [1:0]  aux_out;
    logic [1:0]  aux_oe;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n;

    serial_board_io_status_regs dut (
        .i_clk(clk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_irq_ctrl(serial_board_io_status_pkg::irq_ctrl_t'(ctrl)),
        .i_irq_lines(serial_board_io_status_pkg::irq_lines_t'(lines)),
        .i_full_duplex(duplex), .o_irq(irq), .i_uart_rx_ready(rx_rdy), .i_uart_tx_ready(tx_rdy),
        .i_bg_read_en(bg_en), .i_rx_read_start(rd_start), .i_rx_read_done(rd_done),
        .o_rx_read_abort(abort), .o_abort_data(abort_data), .i_user_switch_bits(sw),
        .i_line_in(line_in), .i_sys_line_out(sys_out), .i_sys_line_oe(sys_oe),
        .o_line_out(line_out), .o_line_oe(line_oe), .o_line_term(line_term),
        .i_uart_out(uart_out), .i_controller_sync(sync), .i_rs232_in(rs_in), .i_aux_in(aux_in),
        .o_rs232_out(rs_out), .o_aux_out(aux_out), .o_aux_oe(aux_oe)
    );

    serial_line_far_end far_end (
        .i_line_oe(line_oe), .i_line_out(line_out), .i_far_val(far_val), .o_line_in(line_in)
    );

    always #5 clk = ~clk;

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(name, exp, rdata);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // Start a read on mask, optional done after d cycles; n is cycle of abort or 0
    task automatic fire(input logic [3:0] mask, input int d, output int cnt);
        @(posedge clk);
        rd_start <= mask;
        @(posedge clk);
        rd_start <= 4'h0;
        cnt = 0;
        for (int k = 1; k <= 12; k++) begin
            @(posedge clk);
            rd_done <= (k == d);
            #1;
            if (abort === 1'b1 && cnt == 0) cnt = k;
        end
    endtask

    task automatic t_reset();
        rd_chk(8'h10, 32'h0, "term rst");
        rd_chk(8'h28, 32'h0000_03ff, "rs232 out rst");
        rd_chk(8'h38, 32'h0000_ffff, "preload rst");
        rd_chk(8'h30, 32'h0, "unmapped");
    endtask

    task automatic t_switch();
        @(posedge clk);
        sw <= 8'ha5;
        wr_reg(8'h04, 32'hffff_ffff);
        rd_chk(8'h04, 32'h0000_00a5, "switch");
        @(posedge clk);
        sw <= 8'h3c;
        rd_chk(8'h04, 32'h0000_003c, "switch live");
    endtask

    task automatic t_lines();
        @(posedge clk);
        sys_out <= 16'hff30;
        far_val <= 16'hc3c3;
        wr_reg(8'h10, 32'hffff_1234);
        rd_chk(8'h10, 32'h0000_1234, "term");
        wr_reg(8'h14, 32'h0000_00ff);
        wr_reg(8'h18, 32'h0000_000f);
        wr_reg(8'h1c, 32'h0000_aaa5);
        settle();
        chk("term pins", 32'h1234, {16'h0, line_term});
        chk("line oe", 32'h00ff, {16'h0, line_oe});
        chk("line out", 32'h0035, {16'h0, line_out & 16'h00ff});
        rd_chk(8'h20, 32'h0000_c300, "readback");
        @(posedge clk);
        duplex <= 2'h1;
        sys_oe <= 16'hf00f;
        settle();
        chk("duplex oe", 32'h000f, {16'h0, line_oe});
        @(posedge clk);
        duplex <= 2'h3;
        settle();
        chk("duplex b oe", 32'hf00f, {16'h0, line_oe});
    endtask

    task automatic t_rs232();
        @(posedge clk);
        uart_out <= 8'ha0;
        sync     <= 2'h2;
        rs_in    <= 8'h3c;
        aux_in   <= 2'h2;
        wr_reg(8'h24, 32'hffff_f10f);
        rd_chk(8'h24, 32'h0000_010f, "rs232 src");
        wr_reg(8'h28, 32'h0000_0205);
        settle();
        chk("rs232 pins", 32'ha5, {24'h0, rs_out});
        chk("aux oe", 32'h1, {30'h0, aux_oe});
        chk("aux out", 32'h0, {30'h0, aux_out});
        rd_chk(8'h2c, 32'h0000_023c, "rs232 rdbk");
    endtask

    task automatic t_irq();
        @(posedge clk);
        lines  <= 5'h15;
        ctrl   <= 8'h11;
        rx_rdy <= 4'h3;
        tx_rdy <= 4'hc;
        rd_chk(8'h08, 32'h00c3_58b1, "status poll");
        chk("irq masked", 32'h0, {31'h0, irq});
        @(posedge clk);
        ctrl <= 8'h91;
        rd_chk(8'h08, 32'h00c3_58b3, "status out");
        chk("irq on", 32'h1, {31'h0, irq});
        @(posedge clk);
        lines <= 5'h00;
        rd_chk(8'h08, 32'h00c3_5800, "status drop");
        chk("irq drop", 32'h0, {31'h0, irq});
        wr_reg(8'h08, 32'h0000_e800);
        rd_chk(8'h08, 32'h00c3_1000, "clear part");
        wr_reg(8'h08, 32'h0000_1000);
        rd_chk(8'h08, 32'h00c3_0000, "clear rest");
        @(posedge clk);
        ctrl <= 8'ha0;
        settle();
        chk("irq forced", 32'h1, {31'h0, irq});
        rd_chk(8'h08, 32'h00c3_0003, "status forced");
    endtask

    task automatic t_timeout();
        wr_reg(8'h38, 32'hffff_0003);
        wr_reg(8'h3c, 32'h1234_beef);
        rd_chk(8'h3c, 32'h0000_beef, "tmo data");
        @(posedge clk);
        ctrl  <= 8'h80;
        bg_en <= 4'h2;
        fire(4'h1, 0, n);
        chk("no bg abort", 32'h0, n);
        fire(4'h2, 0, n);
        chk("abort time", 32'h4, n);
        chk("abort data", 32'hbeef, {16'h0, abort_data});
        rd_chk(8'h08, 32'h00c3_0400, "timer latch");
        chk("irq timer off", 32'h0, {31'h0, irq});
        @(posedge clk);
        ctrl <= 8'hc0;
        rd_chk(8'h08, 32'h00c3_0403, "timer irq");
        chk("irq timer on", 32'h1, {31'h0, irq});
        wr_reg(8'h08, 32'h0000_0400);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        fire(4'h2, 1, n);
        chk("done no abort", 32'h0, n);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_switch();
        t_lines();
        t_rs232();
        t_irq();
        t_timeout();
        wrap_up();
    end
endmodule // serial_board_io_status_regs_tb_top
